//--- rtl/slave_diag_object_bank.v
// Object dictionary bank for diagnosis, error status and sync supervision.
`timescale 1ns/1ps
`include "slave_diag_defines.vh"
module slave_diag_object_bank #(
  parameter SEC_CYCLES = `SEC_NS / `CLK_NS
) (
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire [1:0] tool_mode_i,
  input wire dc_mode_i,
  input wire [3:0] al_state_i,
  input wire obj_req_i,
  input wire obj_wr_i,
  input wire [15:0] obj_index_i,
  input wire [7:0] obj_sub_i,
  input wire [31:0] obj_wdata_i,
  input wire [7:0] err_event_i,
  input wire link_fail_i,
  input wire link_ok_i,
  input wire sync0_i,
  input wire sensor_busy_i,
  input wire [7:0] sensor_cfg_count_i,
  input wire [7:0] sensor_found_count_i,
  output reg obj_ack_o,
  output reg obj_err_o,
  output reg [31:0] obj_rdata_o,
  output reg [7:0] ctrl_err_status_o,
  output reg hist_erase_o,
  output reg comm_fault_o,
  output reg sync_err_o,
  output reg sensor_busy_o,
  output reg sensor_fault_o
);

  // The prescaler end value is cut to the 27-bit counter on purpose.
  localparam [31:0] SEC_LAST_W = SEC_CYCLES - 1;
  localparam [26:0] SEC_LAST = SEC_LAST_W[26:0];
  localparam [1:0] W_IDLE = 2'h0;
  localparam [1:0] W_WAIT = 2'h1;
  localparam [1:0] W_DONE = 2'h2;

  reg rst_meta;
  reg rst_sync;
  reg [7:0] err_reset_val;
  reg [31:0] hist_key;
  reg [7:0] fault_cnt_set;
  reg [15:0] sync_tmo_set;
  reg [7:0] fault_cnt_run;
  reg [15:0] sync_tmo_run;
  reg [3:0] prev_state;
  reg [4:0] fail_run;
  reg [1:0] wait_state;
  reg [26:0] presc;
  reg [15:0] secs;
  reg [31:0] next_rdata;
  reg next_err;
  reg [7:0] tx_count;
  wire rd = obj_req_i & ~obj_wr_i;
  wire wr = obj_req_i & obj_wr_i;
  wire enter_safeop = (prev_state == `ST_PREOP) &&
                      (al_state_i == `ST_SAFEOP);
  wire in_safe_or_op = (al_state_i == `ST_SAFEOP) ||
                       (al_state_i == `ST_OP);
  wire hit_clr = wr && !next_err && (obj_index_i == `IDX_CTRL_ERR) &&
                 (obj_sub_i == `SUB_2);
  wire hit_key = wr && !next_err && (obj_index_i == `IDX_HIST_CLR);
  wire hit_cnt = wr && !next_err && (obj_index_i == `IDX_FAULT_CNT);
  wire hit_tmo = wr && !next_err && (obj_index_i == `IDX_SYNC_TMO);
  wire [15:0] tmo_limit = (sync_tmo_run == `SYNC_TMO_RST) ?
                          `SYNC_TMO_DFLT_S : sync_tmo_run;

  // Returns one entry of the default transmit assignment for a tool mode.
  function [15:0] tx_entry;
    input [1:0] mode;
    input [7:0] sub;
    begin
      tx_entry = 16'h0000;
      if (mode == `MODE_OLD) begin
        case (sub)
          8'h01: tx_entry = 16'h1B00;
          8'h02: tx_entry = 16'h1B01;
          8'h03: tx_entry = 16'h1B08;
          8'h04: tx_entry = 16'h1B0A;
          8'h05: tx_entry = 16'h1B0D;
          default: tx_entry = 16'h0000;
        endcase
      end else if (mode == `MODE_OTHER) begin
        case (sub)
          8'h01: tx_entry = 16'h1B04;
          8'h02: tx_entry = 16'h1B05;
          8'h03: tx_entry = 16'h1B09;
          8'h04: tx_entry = 16'h1B0A;
          8'h05: tx_entry = 16'h1B0B;
          8'h06: tx_entry = 16'h1B10;
          8'h07: tx_entry = 16'h1B12;
          8'h08: tx_entry = 16'h1B14;
          8'h09: tx_entry = 16'h1B16;
          8'h0A: tx_entry = 16'h1B18;
          8'h0B: tx_entry = 16'h1B1A;
          8'h0C: tx_entry = 16'h1B1C;
          8'h0D: tx_entry = 16'h1B1E;
          default: tx_entry = 16'h0000;
        endcase
      end else begin
        case (sub)
          8'h01: tx_entry = 16'h1B00;
          8'h02: tx_entry = 16'h1B01;
          8'h03: tx_entry = 16'h1B08;
          8'h04: tx_entry = 16'h1B0A;
          8'h05: tx_entry = 16'h1B0B;
          8'h06: tx_entry = 16'h1B10;
          8'h07: tx_entry = 16'h1B12;
          8'h08: tx_entry = 16'h1B14;
          8'h09: tx_entry = 16'h1B16;
          8'h0A: tx_entry = 16'h1B18;
          8'h0B: tx_entry = 16'h1B1A;
          8'h0C: tx_entry = 16'h1B1C;
          8'h0D: tx_entry = 16'h1B1E;
          8'h0E: tx_entry = 16'h1BFF;
          default: tx_entry = 16'h0000;
        endcase
      end
    end
  endfunction

  // Releases the asynchronous reset through two flip-flops.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Number of transmit entries in the assignment of the current tool.
  always @* begin
    if (tool_mode_i == `MODE_OLD) begin
      tx_count = `TX_COUNT_OLD;
    end else if (tool_mode_i == `MODE_OTHER) begin
      tx_count = `TX_COUNT_OTHER;
    end else begin
      tx_count = `TX_COUNT_FULL;
    end
  end

  // Decodes an object access into read data and an abort flag.
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (obj_index_i == `IDX_RX_ASSIGN) begin
      // No receive mappings exist, so the entry is read-only.
      next_err = obj_wr_i || (obj_sub_i != `SUB_0);
      next_rdata = {24'h00_0000, `RX_COUNT};
    end else if (obj_index_i == `IDX_TX_ASSIGN) begin
      // The default assignments are fixed and cannot be rewritten.
      next_err = obj_wr_i || (obj_sub_i > tx_count);
      if (obj_sub_i == `SUB_0) begin
        next_rdata = {24'h00_0000, tx_count};
      end else begin
        next_rdata = {16'h0000, tx_entry(tool_mode_i, obj_sub_i)};
      end
    end else if (obj_index_i == `IDX_CTRL_ERR) begin
      if (obj_sub_i == `SUB_0) begin
        next_err = obj_wr_i;
        next_rdata = {24'h00_0000, `CTRL_ERR_SUBS};
      end else if (obj_sub_i == `SUB_1) begin
        next_err = obj_wr_i;
        next_rdata = {24'h00_0000, ctrl_err_status_o};
      end else if (obj_sub_i == `SUB_2) begin
        next_rdata = {24'h00_0000, err_reset_val};
      end else begin
        next_err = 1'b1;
      end
    end else if (obj_index_i == `IDX_HIST_CLR) begin
      // Only the key is a valid value for this object.
      next_err = obj_wr_i && (obj_wdata_i != `ERASE_KEY);
      next_rdata = hist_key;
    end else if (obj_index_i == `IDX_FAULT_CNT) begin
      next_err = !dc_mode_i || (obj_wr_i &&
                 (obj_wdata_i[7:0] > `FAULT_CNT_MAX));
      next_rdata = {24'h00_0000, fault_cnt_set};
    end else if (obj_index_i == `IDX_SYNC_TMO) begin
      next_err = !dc_mode_i || (obj_wr_i &&
                 (obj_wdata_i[15:0] > `SYNC_TMO_MAX));
      next_rdata = {16'h0000, sync_tmo_set};
    end else if (obj_index_i == `IDX_SENSOR) begin
      next_err = obj_wr_i || (obj_sub_i > `SUB_2);
      if (obj_sub_i == `SUB_0) begin
        next_rdata = {24'h00_0000, `SENSOR_SUBS};
      end else if (obj_sub_i == `SUB_1) begin
        next_rdata = {31'h0000_0000, sensor_busy_o};
      end else begin
        next_rdata = {31'h0000_0000, sensor_fault_o};
      end
    end else begin
      next_err = 1'b1;
    end
  end

  // Registers the answer to each access one cycle after the request.
  always @(posedge ref_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      obj_ack_o <= 1'b0;
      obj_err_o <= 1'b0;
      obj_rdata_o <= 32'h0000_0000;
    end else begin
      obj_ack_o <= obj_req_i;
      obj_err_o <= obj_req_i & next_err;
      obj_rdata_o <= (rd && !next_err) ? next_rdata : 32'h0000_0000;
    end
  end

  // Error status, clear entry and history erase key.
  always @(posedge ref_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      ctrl_err_status_o <= 8'h00;
      err_reset_val <= 8'h00;
      hist_key <= 32'h0000_0000;
      hist_erase_o <= 1'b0;
    end else begin
      // A new event in the clear cycle keeps its bit set.
      if (hit_clr) begin
        ctrl_err_status_o <= (ctrl_err_status_o & ~obj_wdata_i[7:0]) |
                             err_event_i;
        err_reset_val <= obj_wdata_i[7:0];
      end else begin
        ctrl_err_status_o <= ctrl_err_status_o | err_event_i;
      end
      if (hit_key) begin
        hist_key <= obj_wdata_i;
      end
      hist_erase_o <= hit_key;
    end
  end

  // Settings that read back, and their copies latched for operation.
  always @(posedge ref_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      fault_cnt_set <= `FAULT_CNT_RST;
      sync_tmo_set <= `SYNC_TMO_RST;
      fault_cnt_run <= `FAULT_CNT_RST;
      sync_tmo_run <= `SYNC_TMO_RST;
      prev_state <= 4'h0;
    end else begin
      prev_state <= al_state_i;
      if (hit_cnt) begin
        fault_cnt_set <= obj_wdata_i[7:0];
      end
      if (hit_tmo) begin
        sync_tmo_set <= obj_wdata_i[15:0];
      end
      if (enter_safeop) begin
        fault_cnt_run <= fault_cnt_set;
        sync_tmo_run <= sync_tmo_set;
      end
    end
  end

  // Counts consecutive link failures against the latched setting.
  always @(posedge ref_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      fail_run <= 5'h00;
      comm_fault_o <= 1'b0;
    end else if (!dc_mode_i || link_ok_i) begin
      fail_run <= 5'h00;
      comm_fault_o <= 1'b0;
    end else if (link_fail_i) begin
      if (fail_run <= fault_cnt_run[4:0]) begin
        fail_run <= fail_run + 5'h01;
      end
      if (fail_run >= fault_cnt_run[4:0]) begin
        comm_fault_o <= 1'b1;
      end
    end
  end

  // Waits in seconds for the first sync pulse after entering safe-op.
  always @(posedge ref_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      wait_state <= W_IDLE;
      presc <= 27'h000_0000;
      secs <= 16'h0000;
      sync_err_o <= 1'b0;
    end else if (!in_safe_or_op || !dc_mode_i) begin
      wait_state <= W_IDLE;
      presc <= 27'h000_0000;
      secs <= 16'h0000;
      sync_err_o <= 1'b0;
    end else begin
      case (wait_state)
        W_IDLE: begin
          if (enter_safeop) begin
            wait_state <= W_WAIT;
            presc <= 27'h000_0000;
            secs <= 16'h0000;
          end
        end
        W_WAIT: begin
          if (sync0_i) begin
            wait_state <= W_DONE;
          end else if (secs >= tmo_limit) begin
            sync_err_o <= 1'b1;
            wait_state <= W_DONE;
          end else if (presc == SEC_LAST) begin
            presc <= 27'h000_0000;
            secs <= secs + 16'h0001;
          end else begin
            presc <= presc + 27'h000_0001;
          end
        end
        default: begin
          wait_state <= W_DONE;
        end
      endcase
    end
  end

  // Sensor link flags follow the amplifier exchange and the count check.
  always @(posedge ref_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      sensor_busy_o <= 1'b0;
      sensor_fault_o <= 1'b0;
    end else begin
      sensor_busy_o <= sensor_busy_i;
      sensor_fault_o <= (sensor_cfg_count_i !=
                         sensor_found_count_i);
    end
  end

endmodule // slave_diag_object_bank

//--- rtl/slave_diag_defines.vh
// Constants of the slave diagnosis object bank.
`ifndef SLAVE_DIAG_DEFINES_VH
`define SLAVE_DIAG_DEFINES_VH
`define IDX_RX_ASSIGN 16'h1C12
`define IDX_TX_ASSIGN 16'h1C13
`define IDX_CTRL_ERR 16'h2002
`define IDX_HIST_CLR 16'h2100
`define IDX_FAULT_CNT 16'h2200
`define IDX_SYNC_TMO 16'h2201
`define IDX_SENSOR 16'h3000
`define SUB_0 8'h00
`define SUB_1 8'h01
`define SUB_2 8'h02
`define CTRL_ERR_SUBS 8'h02
`define SENSOR_SUBS 8'h08
`define RX_COUNT 8'h00
`define TX_COUNT_FULL 8'h0E
`define TX_COUNT_OLD 8'h05
`define TX_COUNT_OTHER 8'h0D
`define MODE_FULL 2'h0
`define MODE_OLD 2'h1
`define MODE_OTHER 2'h2
`define ERASE_KEY 32'h6C63_6C65
`define FAULT_CNT_RST 8'h01
`define FAULT_CNT_MAX 8'h0F
`define SYNC_TMO_RST 16'h0000
`define SYNC_TMO_MAX 16'h0258
`define SYNC_TMO_DFLT_S 16'h0078
`define SEC_NS 1000000000
`define CLK_NS 10
`define ST_PREOP 4'h2
`define ST_SAFEOP 4'h4
`define ST_OP 4'h8
`endif

//--- tb/slave_diag_object_bank_checker.sv
// Port assertions for the diagnosis object bank.
`timescale 1ns/1ps
module slave_diag_object_bank_checker #(
  parameter SEC_CYCLES = 4
) (
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire dc_mode_i,
  input wire obj_req_i,
  input wire obj_wr_i,
  input wire [15:0] obj_index_i,
  input wire [7:0] obj_sub_i,
  input wire [31:0] obj_wdata_i,
  input wire [7:0] err_event_i,
  input wire link_fail_i,
  input wire link_ok_i,
  input wire [7:0] sensor_cfg_count_i,
  input wire [7:0] sensor_found_count_i,
  input wire obj_err_o,
  input wire [7:0] ctrl_err_status_o,
  input wire hist_erase_o,
  input wire comm_fault_o,
  input wire sensor_fault_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // Decoded write requests for the watched objects.
  wire wr_q = obj_req_i && obj_wr_i;
  wire key_ok = obj_wdata_i == 32'h6C63_6C65;
  wire hist_wr = wr_q && obj_index_i == 16'h2100;
  wire stat_wr = wr_q && obj_index_i == 16'h2002;

  a_erase_on_key: assert property (
    hist_erase_o |-> $past(hist_wr && key_ok))
    else $error("erase without key write");
  a_bad_key: assert property (
    hist_wr && !key_ok |=> obj_err_o && !hist_erase_o)
    else $error("bad key not refused");
  a_status_ro: assert property (
    stat_wr && obj_sub_i == 8'h01 |=> obj_err_o)
    else $error("status write accepted");
  a_status_set: assert property (
    |err_event_i |=>
      (ctrl_err_status_o & $past(err_event_i)) == $past(err_event_i))
    else $error("event bit not held");
  a_status_clear: assert property (
    stat_wr && obj_sub_i == 8'h02 && err_event_i == 8'h00 |=>
      (ctrl_err_status_o & $past(obj_wdata_i[7:0])) == 8'h00)
    else $error("status bits not cleared");
  a_fault_cause: assert property (
    $rose(comm_fault_o) |-> $past(link_fail_i))
    else $error("fault without failure");
  a_fault_cleared: assert property (
    link_ok_i && !link_fail_i |=> !comm_fault_o)
    else $error("fault kept after good exchange");
  a_dc_objects: assert property (
    obj_req_i && !dc_mode_i && obj_index_i[15:1] == 15'h1100 |=> obj_err_o)
    else $error("sync mode object answered");
  a_sync_range: assert property (
    wr_q && obj_index_i == 16'h2201 && obj_wdata_i[15:0] > 16'h0258 |=>
      obj_err_o)
    else $error("timeout out of range accepted");
  a_link_fault: assert property (
    $past(arst_n_i, 4) |->
      sensor_fault_o == $past(sensor_cfg_count_i != sensor_found_count_i))
    else $error("link fault flag wrong");
endmodule // slave_diag_object_bank_checker

bind slave_diag_object_bank slave_diag_object_bank_checker
  #(.SEC_CYCLES(SEC_CYCLES)) i_checker (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .dc_mode_i(dc_mode_i),
    .obj_req_i(obj_req_i),
    .obj_wr_i(obj_wr_i),
    .obj_index_i(obj_index_i),
    .obj_sub_i(obj_sub_i),
    .obj_wdata_i(obj_wdata_i),
    .err_event_i(err_event_i),
    .link_fail_i(link_fail_i),
    .link_ok_i(link_ok_i),
    .sensor_cfg_count_i(sensor_cfg_count_i),
    .sensor_found_count_i(sensor_found_count_i),
    .obj_err_o(obj_err_o),
    .ctrl_err_status_o(ctrl_err_status_o),
    .hist_erase_o(hist_erase_o),
    .comm_fault_o(comm_fault_o),
    .sensor_fault_o(sensor_fault_o)
  );

//--- tb/bus_master_model.sv
// Behavioural fieldbus master issuing object accesses.
`timescale 1ns/1ps
module bus_master_model (
  input wire clk_i,
  input wire ack_i,
  input wire err_i,
  input wire busy_i,
  input wire [31:0] rdata_i,
  output logic req_o = 1'b0,
  output logic wr_o = 1'b0,
  output logic [15:0] index_o = 16'h0,
  output logic [7:0] sub_o = 8'h0,
  output logic [31:0] wdata_o = 32'h0
);
  logic got_err;
  logic [31:0] got_data;
  // One access; assignments stay at defaults, under the data limit.
  task automatic access(input logic w, input logic [15:0] i,
                        input logic [7:0] s, input logic [31:0] d);
    @(negedge clk_i);
    while (busy_i && i > 16'h3000) @(negedge clk_i);
    req_o = 1'b1;
    wr_o = w;
    index_o = i;
    sub_o = s;
    wdata_o = d;
    @(negedge clk_i);
    req_o = 1'b0;
    wdata_o = ~d; // Released data lines do not keep the last value.
    got_err = ack_i ? err_i : 1'bx;
    got_data = rdata_i;
  endtask
endmodule // bus_master_model

//--- tb/slave_diag_object_bank_test.sv
// Self-checking bench for the diagnosis object bank.
`timescale 1ns/1ps
module slave_diag_object_bank_test;
  localparam bit OK = 1'h0;
  localparam bit AB = 1'h1;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [1:0] tool_mode_i = 2'h1;
  logic dc_mode_i = 1'b0;
  logic [3:0] al_state_i = 4'h2;
  logic [7:0] err_event_i = 8'h0;
  logic link_fail_i = 1'b0;
  logic link_ok_i = 1'b0;
  logic sync0_i = 1'b0;
  logic sensor_busy_i = 1'b0;
  logic [7:0] sensor_cfg_count_i = 8'h3;
  logic [7:0] sensor_found_count_i = 8'h3;
  wire obj_req_i, obj_wr_i, obj_ack_o, obj_err_o, hist_erase_o;
  wire comm_fault_o, sync_err_o, sensor_busy_o, sensor_fault_o;
  wire [15:0] obj_index_i;
  wire [7:0] obj_sub_i, ctrl_err_status_o;
  wire [31:0] obj_wdata_i, obj_rdata_o;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  slave_diag_object_bank #(.SEC_CYCLES(4)) i_slave_diag_object_bank (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .tool_mode_i(tool_mode_i),
    .dc_mode_i(dc_mode_i), .al_state_i(al_state_i), .obj_req_i(obj_req_i),
    .obj_wr_i(obj_wr_i), .obj_index_i(obj_index_i), .obj_sub_i(obj_sub_i),
    .obj_wdata_i(obj_wdata_i), .err_event_i(err_event_i),
    .link_fail_i(link_fail_i), .link_ok_i(link_ok_i), .sync0_i(sync0_i),
    .sensor_busy_i(sensor_busy_i), .sensor_cfg_count_i(sensor_cfg_count_i),
    .sensor_found_count_i(sensor_found_count_i), .obj_ack_o(obj_ack_o),
    .obj_err_o(obj_err_o), .obj_rdata_o(obj_rdata_o),
    .ctrl_err_status_o(ctrl_err_status_o), .hist_erase_o(hist_erase_o),
    .comm_fault_o(comm_fault_o), .sync_err_o(sync_err_o),
    .sensor_busy_o(sensor_busy_o), .sensor_fault_o(sensor_fault_o));
  bus_master_model i_bus_master_model (.clk_i(ref_clk_i), .ack_i(obj_ack_o),
    .err_i(obj_err_o), .busy_i(sensor_busy_o), .rdata_i(obj_rdata_o),
    .req_o(obj_req_i), .wr_o(obj_wr_i), .index_o(obj_index_i),
    .sub_o(obj_sub_i), .wdata_o(obj_wdata_i));

  // Free-running clock and a cycle ceiling against hangs.
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // One access with its abort flag and data judged; aborts return zero.
  task automatic acc(input string n, input logic w, input logic [15:0] i,
                     input logic [7:0] s, input logic [31:0] d, e, x);
    i_bus_master_model.access(w, i, s, d);
    check(n, {31'h0, i_bus_master_model.got_err}, e);
    check(n, i_bus_master_model.got_data, x);
  endtask

  task automatic t_assign();
    acc("tx count", 0, 16'h1C13, 8'h00, 0, OK, 8'h05);
    acc("tx fifth", 0, 16'h1C13, 8'h05, 0, OK, 16'h1B0D);
    acc("tx sixth", 0, 16'h1C13, 8'h06, 0, AB, 0);
    acc("rx count", 0, 16'h1C12, 8'h00, 0, OK, 0);
    acc("tx write", 1, 16'h1C13, 8'h01, 16'h1B04, AB, 0);
    tool_mode_i = 2'h2;
    acc("tx count", 0, 16'h1C13, 8'h00, 0, OK, 8'h0D);
    acc("tx first", 0, 16'h1C13, 8'h01, 0, OK, 16'h1B04);
    acc("tx second", 0, 16'h1C13, 8'h02, 0, OK, 16'h1B05);
    acc("tx past", 0, 16'h1C13, 8'h0E, 0, AB, 0);
    tool_mode_i = 2'h0;
    acc("tx count", 0, 16'h1C13, 8'h00, 0, OK, 8'h0E);
    acc("tx last", 0, 16'h1C13, 8'h0E, 0, OK, 16'h1BFF);
    // The spare mode code behaves as the full default assignment.
    tool_mode_i = 2'h3;
    acc("tx count", 0, 16'h1C13, 8'h00, 0, OK, 8'h0E);
    acc("tx last", 0, 16'h1C13, 8'h0E, 0, OK, 16'h1BFF);
    tool_mode_i = 2'h0;
  endtask

  task automatic t_history();
    acc("bad key", 1, 16'h2100, 8'h00, 32'h6C63_6C66, AB, 0);
    check("erase", {31'h0, hist_erase_o}, 0);
    acc("key", 1, 16'h2100, 8'h00, 32'h6C63_6C65, OK, 0);
    check("erase", {31'h0, hist_erase_o}, 1);
  endtask

  task automatic t_status();
    acc("entries", 0, 16'h2002, 8'h00, 0, OK, 8'h02);
    acc("status", 0, 16'h2002, 8'h01, 0, OK, 0);
    err_event_i = 8'hA5;
    @(negedge ref_clk_i);
    err_event_i = 8'h00;
    acc("status", 0, 16'h2002, 8'h01, 0, OK, 8'hA5);
    acc("status wr", 1, 16'h2002, 8'h01, 8'hFF, AB, 0);
    acc("clear", 1, 16'h2002, 8'h02, 8'h0F, OK, 0);
    check("status", {24'h0, ctrl_err_status_o}, 8'hA0);
    acc("clear rd", 0, 16'h2002, 8'h02, 0, OK, 8'h0F);
  endtask

  // Back to pre-operational, set the wait, then enter safe-operational.
  task automatic enter(input logic [15:0] t);
    al_state_i = 4'h2;
    acc("tmo", 1, 16'h2201, 8'h00, t, OK, 0);
    check("sync err", {31'h0, sync_err_o}, 0);
    al_state_i = 4'h4;
  endtask

  task automatic sync_wait(input int lo, input int hi);
    repeat (lo) @(negedge ref_clk_i);
    check("early sync err", {31'h0, sync_err_o}, 0);
    repeat (hi) if (!sync_err_o) @(negedge ref_clk_i);
    check("sync err", {31'h0, sync_err_o}, 1);
  endtask

  task automatic fails(input int k, input logic x);
    repeat (k) begin
      link_fail_i = 1'b1;
      @(negedge ref_clk_i);
      link_fail_i = 1'b0;
      @(negedge ref_clk_i);
    end
    check("fault", {31'h0, comm_fault_o}, x);
  endtask

  task automatic t_dc();
    acc("no dc", 0, 16'h2200, 8'h00, 0, AB, 0);
    dc_mode_i = 1'b1;
    acc("cnt", 0, 16'h2200, 8'h00, 0, OK, 8'h01);
    acc("cnt big", 1, 16'h2200, 8'h00, 8'h10, AB, 0);
    acc("cnt", 1, 16'h2200, 8'h00, 8'h02, OK, 0);
    acc("tmo", 0, 16'h2201, 8'h00, 0, OK, 0);
    acc("tmo big", 1, 16'h2201, 8'h00, 16'h0259, AB, 0);
    enter(16'h0003);
    acc("tmo late", 1, 16'h2201, 8'h00, 16'h0258, OK, 0);
    sync_wait(4, 12);
    acc("cnt late", 1, 16'h2200, 8'h00, 8'h00, OK, 0);
    acc("cnt rd", 0, 16'h2200, 8'h00, 0, OK, 8'h00);
    fails(2, 0);
    fails(1, 1);
    link_ok_i = 1'b1;
    @(negedge ref_clk_i);
    link_ok_i = 1'b0;
    check("fault", {31'h0, comm_fault_o}, 0);
    enter(16'h0000);
    sync_wait(470, 30);
    enter(16'h0003);
    // The wait starts on the entry edge, so the pulse comes a cycle later.
    @(negedge ref_clk_i);
    sync0_i = 1'b1;
    @(negedge ref_clk_i);
    sync0_i = 1'b0;
    repeat (20) @(negedge ref_clk_i);
    check("sync err", {31'h0, sync_err_o}, 0);
  endtask

  task automatic t_sensor();
    sensor_cfg_count_i = 8'h04;
    sensor_busy_i = 1'b1;
    acc("entries", 0, 16'h3000, 8'h00, 0, OK, 8'h08);
    acc("busy", 0, 16'h3000, 8'h01, 0, OK, 1);
    acc("link fault", 0, 16'h3000, 8'h02, 0, OK, 1);
    sensor_cfg_count_i = 8'h03;
    sensor_busy_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    check("link fault", {31'h0, sensor_fault_o}, 0);
    check("busy", {31'h0, sensor_busy_o}, 0);
  endtask

  // Reset for six cycles, then run every scenario.
  initial begin
    repeat (6) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_assign();
    t_history();
    t_status();
    t_dc();
    t_sensor();
    complete_run();
  end
endmodule // slave_diag_object_bank_test
